// *** rst_init_pkg.sv ***
// Package of register offsets, reset images and cause encodings for the reset state initializer
package rst_init_pkg;
  // Register offsets
  localparam logic [7:0] OFF_INDIRECT   = 8'h00;
  localparam logic [7:0] OFF_TIMER_ZERO_COUNT       = 8'h01;
  localparam logic [7:0] OFF_PCL        = 8'h02;
  localparam logic [7:0] OFF_FLAGS      = 8'h03;
  localparam logic [7:0] OFF_POINTER    = 8'h04;
  localparam logic [7:0] OFF_PORT_A_LATCH      = 8'h05;
  localparam logic [7:0] OFF_PORT_B_LATCH      = 8'h06;
  localparam logic [7:0] OFF_PCHI       = 8'h0a;
  localparam logic [7:0] OFF_IRQCTL     = 8'h0b;
  localparam logic [7:0] OFF_PIRQ       = 8'h0c;
  localparam logic [7:0] OFF_CMP        = 8'h1f;
  localparam logic [7:0] OFF_PRESC      = 8'h81;
  localparam logic [7:0] OFF_DIRA       = 8'h85;
  localparam logic [7:0] OFF_DIRB       = 8'h86;
  localparam logic [7:0] OFF_PIE        = 8'h8c;
  localparam logic [7:0] OFF_PWR        = 8'h8e;
  localparam logic [7:0] OFF_VREF       = 8'h9f;
  localparam logic [7:0] OFF_WACC       = 8'hf0;
  // Implemented-bit masks
  localparam logic [7:0] MASK_PORT_A_LATCH     = 8'h1f;
  localparam logic [7:0] MASK_PCHI      = 8'h1f;
  localparam logic [7:0] MASK_CMP       = 8'hcf;
  localparam logic [7:0] MASK_VREF      = 8'hef;
  localparam logic [7:0] MASK_PWR       = 8'h03;
  localparam logic [7:0] MASK_PIRQ      = 8'h40;
  localparam logic [7:0] MASK_PIE       = 8'h40;
  // Reset images
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_ONES       = 8'hff;
  localparam logic [7:0] RST_DIRA       = 8'h1f;
  localparam logic [7:0] RST_FLAGS_POR  = 8'h18;
  localparam logic [7:0] RST_PWR_POR    = 8'h00;
  // Field positions
  localparam int FLAG_TO  = 4;   // Time-out flag
  localparam int FLAG_PD  = 3;   // Power-down flag
  localparam int PWR_BOR  = 0;   // Brown-out flag
  localparam int PIRQ_CMP = 6;   // Comparator change flag
  localparam int IRQ_GIE  = 7;   // Global irq enable
  localparam int IRQ_FLG  = 1;   // Irq wake flag bit
  localparam int RC_DIV   = 4;   // Clock output divider
  localparam int VREF_EN  = 7;   // Reference enable bit
  localparam int VREF_OE  = 6;   // Reference onto pin bit
  localparam logic [12:0] PC_RESET  = 13'h0000;
  localparam logic [12:0] PC_VECTOR = 13'h0004;
  // Sequencing state
  typedef enum logic [5:0] {
    ST_RUN   = 6'b000001,
    ST_SLEEP = 6'b000010,
    ST_STEP  = 6'b000100,
    ST_VEC   = 6'b001000,
    ST_HOLD  = 6'b010000,
    ST_IDLE  = 6'b100000
  } state_t;
endpackage

// *** reset_state_initializer.sv ***
// Reset and wake-up initializer for the cpu control registers
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
// Function
// R1: Power-on loads pc 000h, flags 0001 1xxx (low bits cleared here) and power flags 0x.
// R2: External reset while running clears pc and the top three flag bits, rest kept.
// R3: External reset in sleep clears pc and sets flags to 0001 0uuu.
// R4: Brown-out clears pc, flags to 000x xuuu and clears power-flag bit 0; power-on also clears it, other causes keep it.
// R5: Interrupt wake-up resumes at pc+1 with flags uuu1 0uuu and power flags kept.
// R6: With global irq enable set the wake-up runs pc+1 then loads vector 0004h.
// R7: Any wake-up records its source in irq flag bits and leaves other registers alone; here only an interrupt wake sets irq flag bit 1.
// R8: A comparator-change wake-up sets periph flag bit 6; other wake-ups keep it.
// R9: Power-on seen together with another cause wins and applies power-on images.
// R10: Every reset loads vref control with 000- 0000; wake-ups keep it.
// R11: Resets set prescaler and port directions to ones and clear pc low, pc high and comparator.
// R12: Working, timer, pointer and port latches keep contents on all but power-on.
// R13: The time-out and power-down bits follow the reset or wake-up cause.
// R14: Unimplemented bits always read zero.
// R15: In RC mode the clock output toggles at oscillator divided by 4.
// R16: Any reset clears the vref enable, pin drive, range and value bits.
// R17: Cause bits persist until software rewrites them or a new cause overrides.
module reset_state_initializer (
  input  wire logic        sys_clk,        // Core clock
  input  wire logic        reset,          // Synchronous reset, active high
  input  wire logic        power_on,       // Power-on cause pulse
  input  wire logic        external_reset_pin, // External reset request
  input  wire logic        watchdog_timeout, // Watchdog time-out pulse
  input  wire logic        brown_out,      // Brown-out cause pulse
  input  wire logic        sleep_req,      // Core enters sleep
  input  wire logic        irq_wake,       // Interrupt wake request
  input  wire logic        cmp_change,     // Comparator input changed
  input  wire logic        rc_mode,        // RC oscillator mode select
  input  wire logic [7:0]  reg_addr,       // Register address
  input  wire logic [7:0]  reg_wdata,      // Write data
  input  wire logic        reg_wr,         // Write strobe
  input  wire logic        reg_rd,         // Read strobe
  output logic      [7:0]  reg_rdata,      // Read data, one cycle later
  output logic      [12:0] pc_out,         // Program counter
  output logic             sleeping,       // Core is asleep
  output logic             quarter_osc_output, // Clock divided by 4
  output logic             vref_on,        // Reference enable
  output logic             vref_pin_drive  // Reference onto pin
);
  // Sequencing state, program counter and held wake cause
  rst_init_pkg::state_t st_r;
  logic [12:0]          pc_r;
  logic                 irq_woke_r;
  // Register images
  logic [7:0]           wacc_r;
  logic [7:0]           tmr_r;
  logic [7:0]           ptr_r;
  logic [7:0]           port_a_latch_r;
  logic [7:0]           port_b_latch_r;
  logic [7:0]           pchi_r;
  logic [7:0]           irq_r;
  logic [7:0]           pirq_r;
  logic [7:0]           cmp_r;
  logic [7:0]           presc_r;
  logic [7:0]           dira_r;
  logic [7:0]           dirb_r;
  logic [7:0]           pie_r;
  logic [7:0]           pwr_r;
  logic [7:0]           vref_r;
  logic [7:0]           flags_r;
  // Quarter clock divider and cause decode
  logic [1:0]           div_r;
  logic                 qclk_r;
  logic                 por_any;
  logic                 rst_any;
  logic                 wake;
  logic                 wr;

  // Cause decode: power-on dominates any other cause
  assign por_any = reset | power_on; // R9
  assign rst_any = por_any | external_reset_pin | brown_out |
                   (watchdog_timeout & st_r != rst_init_pkg::ST_SLEEP);
  assign wake    = st_r == rst_init_pkg::ST_SLEEP & (irq_wake | watchdog_timeout | cmp_change);
  assign wr      = reg_wr & ~rst_any & ~wake;

  // Sleep and wake sequencing
  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      st_r <= rst_init_pkg::ST_RUN;
    end else begin
      case (st_r)
        rst_init_pkg::ST_RUN: begin
          if (sleep_req) begin
            st_r <= rst_init_pkg::ST_SLEEP;
          end
        end
        rst_init_pkg::ST_SLEEP: begin
          if (wake) begin
            st_r <= rst_init_pkg::ST_STEP;
          end
        end
        rst_init_pkg::ST_STEP: begin
          // Execute pc+1, then vector if enabled
          st_r <= irq_r[rst_init_pkg::IRQ_GIE] & irq_woke_r ?
                  rst_init_pkg::ST_VEC : rst_init_pkg::ST_RUN; // R6
        end
        rst_init_pkg::ST_VEC:  st_r <= rst_init_pkg::ST_RUN;
        rst_init_pkg::ST_HOLD: st_r <= rst_init_pkg::ST_RUN;
        rst_init_pkg::ST_IDLE: st_r <= rst_init_pkg::ST_RUN;
        default:               st_r <= rst_init_pkg::ST_RUN;
      endcase
    end
  end

  // Interrupt wake cause, held for the step after wake-up since the request pulse is gone
  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      irq_woke_r <= 1'b0;
    end else if (wake) begin
      irq_woke_r <= irq_wake | cmp_change; // R6
    end
  end

  // Program counter
  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      pc_r <= rst_init_pkg::PC_RESET; // R1 R2 R3 R4
    end else if (wake) begin
      pc_r <= pc_r + 13'h0001; // R5
    end else if (st_r == rst_init_pkg::ST_STEP &&
                 irq_r[rst_init_pkg::IRQ_GIE] && irq_woke_r) begin
      pc_r <= rst_init_pkg::PC_VECTOR; // R6
    end else if (wr && reg_addr == rst_init_pkg::OFF_PCL) begin
      pc_r <= {pchi_r[4:0], reg_wdata};
    end
  end

  // Cpu flags: time-out and power-down follow the cause
  always_ff @(posedge sys_clk) begin
    if (por_any) begin
      flags_r <= rst_init_pkg::RST_FLAGS_POR; // R1 R13
    end else if (brown_out) begin
      flags_r <= {3'b000, flags_r[4:0]}; // R4
    end else if (external_reset_pin && st_r == rst_init_pkg::ST_SLEEP) begin
      flags_r <= {3'b000, 1'b1, 1'b0, flags_r[2:0]}; // R3 R13
    end else if (external_reset_pin) begin
      flags_r <= {3'b000, flags_r[4:0]}; // R2
    end else if (watchdog_timeout && st_r != rst_init_pkg::ST_SLEEP) begin
      flags_r <= {3'b000, 1'b0, flags_r[3:0]}; // R13
    end else if (wake && irq_wake | cmp_change) begin
      flags_r <= {flags_r[7:5], 1'b1, 1'b0, flags_r[2:0]}; // R5 R13
    end else if (wake) begin
      flags_r <= {flags_r[7:5], 1'b0, 1'b0, flags_r[2:0]}; // R13
    end else if (sleep_req && st_r == rst_init_pkg::ST_RUN) begin
      flags_r[rst_init_pkg::FLAG_PD] <= 1'b0;
    end else if (wr && reg_addr == rst_init_pkg::OFF_FLAGS) begin
      flags_r <= {reg_wdata[7:5], flags_r[4:3], reg_wdata[2:0]}; // R17
    end
  end

  // Power cause flags: bit 0 cleared by brown-out and by power-on
  always_ff @(posedge sys_clk) begin
    if (por_any) begin
      pwr_r <= rst_init_pkg::RST_PWR_POR; // R1
    end else if (brown_out) begin
      pwr_r[rst_init_pkg::PWR_BOR] <= 1'b0; // R4
    end else if (wr && reg_addr == rst_init_pkg::OFF_PWR) begin
      pwr_r <= reg_wdata & rst_init_pkg::MASK_PWR; // R17
    end
  end

  // Registers with fixed reset images, kept on wake-up
  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      vref_r  <= rst_init_pkg::RST_ZERO; // R10 R16
      presc_r <= rst_init_pkg::RST_ONES; // R11
      dirb_r  <= rst_init_pkg::RST_ONES; // R11
      dira_r  <= rst_init_pkg::RST_DIRA; // R11
      pchi_r  <= rst_init_pkg::RST_ZERO; // R11
      cmp_r   <= rst_init_pkg::RST_ZERO; // R11
      pie_r   <= rst_init_pkg::RST_ZERO;
    end else if (wr) begin
      case (reg_addr)
        rst_init_pkg::OFF_VREF:  vref_r  <= reg_wdata & rst_init_pkg::MASK_VREF; // R14
        rst_init_pkg::OFF_PRESC: presc_r <= reg_wdata;
        rst_init_pkg::OFF_DIRB:  dirb_r  <= reg_wdata;
        rst_init_pkg::OFF_DIRA:  dira_r  <= reg_wdata & rst_init_pkg::MASK_PORT_A_LATCH; // R14
        rst_init_pkg::OFF_PCHI:  pchi_r  <= reg_wdata & rst_init_pkg::MASK_PCHI; // R14
        rst_init_pkg::OFF_CMP:   cmp_r   <= reg_wdata & rst_init_pkg::MASK_CMP; // R14
        rst_init_pkg::OFF_PIE:   pie_r   <= reg_wdata & rst_init_pkg::MASK_PIE; // R14
        default: ;
      endcase
    end
  end

  // Interrupt flags record the wake-up source
  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      irq_r  <= rst_init_pkg::RST_ZERO;
      pirq_r <= rst_init_pkg::RST_ZERO;
    end else if (wake) begin
      irq_r[rst_init_pkg::IRQ_FLG] <= irq_r[rst_init_pkg::IRQ_FLG] | irq_wake; // R7
      pirq_r[rst_init_pkg::PIRQ_CMP] <= pirq_r[rst_init_pkg::PIRQ_CMP] | cmp_change; // R8
    end else if (wr && reg_addr == rst_init_pkg::OFF_IRQCTL) begin
      irq_r <= reg_wdata;
    end else if (wr && reg_addr == rst_init_pkg::OFF_PIRQ) begin
      pirq_r <= (reg_wdata & rst_init_pkg::MASK_PIRQ) |
                ({7'h00, cmp_change} << rst_init_pkg::PIRQ_CMP); // Set beats clear
    end else if (cmp_change) begin
      pirq_r[rst_init_pkg::PIRQ_CMP] <= 1'b1;
    end
  end

  // Data registers: zero on power-on stands in for unknown, kept otherwise
  always_ff @(posedge sys_clk) begin
    if (por_any) begin
      wacc_r  <= rst_init_pkg::RST_ZERO; // R12
      tmr_r   <= rst_init_pkg::RST_ZERO;
      ptr_r   <= rst_init_pkg::RST_ZERO;
      port_a_latch_r <= rst_init_pkg::RST_ZERO;
      port_b_latch_r <= rst_init_pkg::RST_ZERO;
    end else if (wr) begin
      case (reg_addr)
        rst_init_pkg::OFF_WACC:    wacc_r  <= reg_wdata;
        rst_init_pkg::OFF_TIMER_ZERO_COUNT:    tmr_r   <= reg_wdata;
        rst_init_pkg::OFF_POINTER: ptr_r   <= reg_wdata;
        rst_init_pkg::OFF_PORT_A_LATCH:   port_a_latch_r <= reg_wdata & rst_init_pkg::MASK_PORT_A_LATCH; // R14
        rst_init_pkg::OFF_PORT_B_LATCH:   port_b_latch_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= rst_init_pkg::RST_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        rst_init_pkg::OFF_INDIRECT: reg_rdata <= rst_init_pkg::RST_ZERO;
        rst_init_pkg::OFF_TIMER_ZERO_COUNT:     reg_rdata <= tmr_r;
        rst_init_pkg::OFF_PCL:      reg_rdata <= pc_r[7:0];
        rst_init_pkg::OFF_FLAGS:    reg_rdata <= flags_r;
        rst_init_pkg::OFF_POINTER:  reg_rdata <= ptr_r;
        rst_init_pkg::OFF_PORT_A_LATCH:    reg_rdata <= port_a_latch_r;
        rst_init_pkg::OFF_PORT_B_LATCH:    reg_rdata <= port_b_latch_r;
        rst_init_pkg::OFF_PCHI:     reg_rdata <= pchi_r;
        rst_init_pkg::OFF_IRQCTL:   reg_rdata <= irq_r;
        rst_init_pkg::OFF_PIRQ:     reg_rdata <= pirq_r;
        rst_init_pkg::OFF_CMP:      reg_rdata <= cmp_r;
        rst_init_pkg::OFF_PRESC:    reg_rdata <= presc_r;
        rst_init_pkg::OFF_DIRA:     reg_rdata <= dira_r;
        rst_init_pkg::OFF_DIRB:     reg_rdata <= dirb_r;
        rst_init_pkg::OFF_PIE:      reg_rdata <= pie_r;
        rst_init_pkg::OFF_PWR:      reg_rdata <= pwr_r;
        rst_init_pkg::OFF_VREF:     reg_rdata <= vref_r;
        rst_init_pkg::OFF_WACC:     reg_rdata <= wacc_r;
        default:                    reg_rdata <= rst_init_pkg::RST_ZERO; // R14
      endcase
    end else begin
      reg_rdata <= rst_init_pkg::RST_ZERO;
    end
  end

  // Quarter-rate clock output in RC mode
  always_ff @(posedge sys_clk) begin
    if (reset || !rc_mode) begin
      div_r  <= 2'b00;
      qclk_r <= 1'b0;
    end else begin
      div_r <= div_r + 2'b01;
      if (div_r[0]) begin
        qclk_r <= ~qclk_r; // R15
      end
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pc_out             <= rst_init_pkg::PC_RESET;
      sleeping           <= 1'b0;
      quarter_osc_output <= 1'b0;
      vref_on            <= 1'b0;
      vref_pin_drive     <= 1'b0;
    end else begin
      pc_out             <= pc_r;
      sleeping           <= st_r == rst_init_pkg::ST_SLEEP;
      quarter_osc_output <= qclk_r;
      vref_on            <= vref_r[rst_init_pkg::VREF_EN]; // R16
      vref_pin_drive     <= vref_r[rst_init_pkg::VREF_OE]; // R16
    end
  end

  // Checks on cause images and wake-up handling
  a_por_flags: assert property (@(posedge sys_clk) // R1
    power_on |=> flags_r == rst_init_pkg::RST_FLAGS_POR)
    else $error("power-on flags image wrong");

  a_ext_pc: assert property (@(posedge sys_clk) // R2
    external_reset_pin |=> pc_r == rst_init_pkg::PC_RESET)
    else $error("pc not cleared on external reset");

  a_sleep_ext: assert property (@(posedge sys_clk) disable iff (reset) // R3
    external_reset_pin && !power_on && !brown_out && st_r == rst_init_pkg::ST_SLEEP
    |=> flags_r[rst_init_pkg::FLAG_TO] && !flags_r[rst_init_pkg::FLAG_PD])
    else $error("external reset in sleep left wrong flags");

  a_bor_bit: assert property (@(posedge sys_clk) disable iff (reset) // R4
    brown_out && !power_on |=> !pwr_r[rst_init_pkg::PWR_BOR])
    else $error("brown-out did not clear bit 0");

  a_wake_pc: assert property (@(posedge sys_clk) disable iff (reset) // R5
    wake && !rst_any |=> pc_r == $past(pc_r) + 13'h0001)
    else $error("wake pc not incremented");

  a_wake_vector: assert property (@(posedge sys_clk) disable iff (reset) // R6
    st_r == rst_init_pkg::ST_STEP && irq_woke_r && irq_r[rst_init_pkg::IRQ_GIE] && !rst_any
    |=> pc_r == rst_init_pkg::PC_VECTOR)
    else $error("interrupt vector not loaded after wake");

  a_wake_record: assert property (@(posedge sys_clk) disable iff (reset) // R7
    wake && irq_wake && !rst_any |=> irq_r[rst_init_pkg::IRQ_FLG])
    else $error("interrupt wake source not recorded");

  a_cmp_wake: assert property (@(posedge sys_clk) disable iff (reset) // R8
    wake && cmp_change && !rst_any |=> pirq_r[rst_init_pkg::PIRQ_CMP])
    else $error("comparator wake not recorded");

  a_por_wins: assert property (@(posedge sys_clk) // R9
    power_on && (external_reset_pin || brown_out || watchdog_timeout)
    |=> flags_r == rst_init_pkg::RST_FLAGS_POR && pwr_r == rst_init_pkg::RST_PWR_POR)
    else $error("power-on did not override another cause");

  a_vref_reset: assert property (@(posedge sys_clk) // R10
    rst_any |=> vref_r == rst_init_pkg::RST_ZERO)
    else $error("vref not cleared by reset");

  a_vref_keep: assert property (@(posedge sys_clk) disable iff (reset) // R10
    wake && !rst_any |=> vref_r == $past(vref_r))
    else $error("vref changed on wake");

  a_dir_reset: assert property (@(posedge sys_clk) // R11
    rst_any |=> dira_r == rst_init_pkg::RST_DIRA && dirb_r == rst_init_pkg::RST_ONES)
    else $error("direction images wrong");

  a_img_reset: assert property (@(posedge sys_clk) // R11
    rst_any |=> presc_r == rst_init_pkg::RST_ONES && pchi_r == rst_init_pkg::RST_ZERO &&
                cmp_r == rst_init_pkg::RST_ZERO)
    else $error("prescaler, latch or comparator image wrong");

  a_data_keep: assert property (@(posedge sys_clk) disable iff (reset) // R12
    rst_any && !power_on |=> wacc_r == $past(wacc_r) && tmr_r == $past(tmr_r) &&
                             ptr_r == $past(ptr_r))
    else $error("data register changed on a non power-on reset");

  a_pd_wake: assert property (@(posedge sys_clk) disable iff (reset) // R13
    wake && !rst_any |=> !flags_r[rst_init_pkg::FLAG_PD])
    else $error("power-down bit not cleared on wake");

  a_wdt_flags: assert property (@(posedge sys_clk) disable iff (reset) // R13
    watchdog_timeout && st_r != rst_init_pkg::ST_SLEEP && !power_on && !brown_out &&
    !external_reset_pin |=> !flags_r[rst_init_pkg::FLAG_TO])
    else $error("time-out bit not cleared on watchdog reset");

  a_unimp_zero: assert property (@(posedge sys_clk) disable iff (reset) // R14
    (vref_r & ~rst_init_pkg::MASK_VREF) == rst_init_pkg::RST_ZERO &&
    (dira_r & ~rst_init_pkg::MASK_PORT_A_LATCH) == rst_init_pkg::RST_ZERO &&
    (pwr_r & ~rst_init_pkg::MASK_PWR) == rst_init_pkg::RST_ZERO)
    else $error("unimplemented bit set");

  a_quarter_idle: assert property (@(posedge sys_clk) disable iff (reset) // R15
    !rc_mode |=> !qclk_r)
    else $error("quarter clock runs outside RC mode");

  a_vref_outs: assert property (@(posedge sys_clk) disable iff (reset) // R16
    !$past(reset) |-> vref_on == $past(vref_r[rst_init_pkg::VREF_EN]) &&
                      vref_pin_drive == $past(vref_r[rst_init_pkg::VREF_OE]))
    else $error("reference outputs do not follow vref control");

  a_cause_keep: assert property (@(posedge sys_clk) disable iff (reset) // R17
    !rst_any && !(wr && reg_addr == rst_init_pkg::OFF_PWR) |=> pwr_r == $past(pwr_r))
    else $error("power cause flags changed with no cause");

  // Main scenarios reached
  c_sleep_wake: cover property (@(posedge sys_clk) st_r == rst_init_pkg::ST_SLEEP ##1 wake);
  c_vector: cover property (@(posedge sys_clk) st_r == rst_init_pkg::ST_VEC);
  c_brown: cover property (@(posedge sys_clk) brown_out && !power_on);
  c_cmp_wake: cover property (@(posedge sys_clk) wake && cmp_change);
  c_ext_sleep: cover property (@(posedge sys_clk)
    external_reset_pin && st_r == rst_init_pkg::ST_SLEEP);
endmodule

// *** testbench.sv ***
// Self-checking testbench for the reset state initializer
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] E_ON = 7'h01, E_EXT = 7'h02, E_WDT = 7'h04, E_BOR = 7'h08;
  localparam logic [6:0] E_SLP = 7'h10, E_IRQ = 7'h20, E_CMP = 7'h40;
  logic        sys_clk;     // Core clock
  logic        reset;       // Synchronous reset
  logic [6:0]  ev;          // Cause and wake pulses
  logic        rc_mode;     // RC oscillator mode
  logic [7:0]  reg_addr;    // Bus address
  logic [7:0]  reg_wdata;   // Bus write data
  logic        reg_wr;      // Write strobe
  logic        reg_rd;      // Read strobe
  logic [7:0]  reg_rdata;   // Read data
  logic [12:0] pc_out;      // Program counter
  logic        sleeping;    // Asleep flag
  logic        quarter_osc_output;
  logic        vref_on;
  logic        vref_pin_drive;
  logic [7:0]  rd_d;        // Last read value
  logic [15:0] rows [0:13]; // Address and expected reset image
  logic        q;
  int          fails;
  int          tests_run;
  int          cycles;
  int          edges;

  reset_state_initializer dut_u (
    .sys_clk(sys_clk), .reset(reset), .power_on(ev[0]), .external_reset_pin(ev[1]),
    .watchdog_timeout(ev[2]), .brown_out(ev[3]), .sleep_req(ev[4]), .irq_wake(ev[5]),
    .cmp_change(ev[6]), .rc_mode(rc_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_out(pc_out),
    .sleeping(sleeping), .quarter_osc_output(quarter_osc_output), .vref_on(vref_on),
    .vref_pin_drive(vref_pin_drive)
  );

  // Clock and hang guard
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus write: one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Bus read, data taken in the cycle after the strobe
  task automatic rck(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_d = reg_rdata;
    chk($sformatf("register %h", a), 16'(rd_d), 16'(e));
  endtask

  // One-cycle cause or wake pulse, then let the images land
  task automatic pulse(input logic [6:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= '0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic pc_is(input logic [12:0] e);
    chk("program counter", 16'(pc_out), 16'(e));
  endtask

  initial begin
    reset = 1'b1;
    ev = '0;
    rc_mode = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fails = 0;
    tests_run = 0;
    cycles = 0;
    rows = '{16'h0200, 16'h0318, 16'h0a00, 16'h0b00, 16'h0c00, 16'h1f00, 16'h81ff,
             16'h851f, 16'h86ff, 16'h8c00, 16'h8e00, 16'h9f00, 16'h5000, 16'h0100};
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      rck(rows[i][15:8], rows[i][7:0]);
    end
    pc_is(rst_init_pkg::PC_RESET);
    $display("test reset images done");
    // Read-only cause bits, unimplemented bits, reference outputs
    wr(8'h03, 8'he5);
    rck(8'h03, 8'hfd);
    wr(8'h05, 8'hff);
    rck(8'h05, 8'h1f);
    wr(8'h9f, 8'h5f);
    rck(8'h9f, 8'h4f);
    chk("reference drive", 16'(vref_pin_drive), 16'h1);
    wr(8'h9f, 8'ha6);
    rck(8'h9f, 8'ha6);
    chk("reference enable", 16'(vref_on), 16'h1);
    wr(8'h01, 8'h5a);
    wr(8'hf0, 8'h3c);
    wr(8'h81, 8'h55);
    wr(8'h86, 8'h00);
    wr(8'h0a, 8'h03);
    wr(8'h02, 8'h40);
    @(posedge sys_clk);
    #1;
    pc_is(13'h0340);
    $display("test register access done");
    // External reset while running
    pulse(E_EXT);
    pc_is(13'h0000);
    rck(8'h03, 8'h1d);
    rck(8'h81, 8'hff);
    rck(8'h86, 8'hff);
    rck(8'h0a, 8'h00);
    rck(8'h9f, 8'h00);
    chk("reference enable", 16'(vref_on), 16'h0);
    rck(8'h01, 8'h5a);
    rck(8'hf0, 8'h3c);
    rck(8'h05, 8'h1f);
    rck(8'h8e, 8'h00);
    $display("test external reset running done");
    // Interrupt wake without and with global enable
    wr(8'h0a, 8'h03);
    wr(8'h02, 8'h40);
    pulse(E_SLP);
    chk("sleeping", 16'(sleeping), 16'h1);
    rck(8'h03, 8'h15);
    pulse(E_IRQ);
    chk("sleeping", 16'(sleeping), 16'h0);
    pc_is(13'h0341);
    rck(8'h03, 8'h15);
    rck(8'h0b, 8'h02);
    rck(8'h0c, 8'h00);
    rck(8'h02, 8'h41);
    wr(8'h0b, 8'h80);
    pulse(E_SLP);
    pulse(E_IRQ);
    pc_is(rst_init_pkg::PC_VECTOR);
    $display("test interrupt wake done");
    // Watchdog reset, then external reset in sleep
    wr(8'h0b, 8'h00);
    pulse(E_WDT);
    pc_is(13'h0000);
    rck(8'h03, 8'h05);
    pulse(E_SLP);
    pulse(E_EXT);
    pc_is(13'h0000);
    rck(8'h03, 8'h15);
    chk("sleeping", 16'(sleeping), 16'h0);
    // Watchdog wake
    wr(8'h02, 8'h10);
    pulse(E_SLP);
    pulse(E_WDT);
    pc_is(13'h0011);
    rck(8'h03, 8'h05);
    $display("test watchdog and sleep reset done");
    // Comparator wake keeps the reference setup
    wr(8'h9f, 8'ha6);
    pulse(E_SLP);
    pulse(E_CMP);
    rck(8'h0c, 8'h40);
    rck(8'h03, 8'h15);
    rck(8'h9f, 8'ha6);
    chk("reference enable", 16'(vref_on), 16'h1);
    $display("test comparator wake done");
    // Brown-out, then power-on beside another cause
    wr(8'h03, 8'he5);
    wr(8'h8e, 8'h01);
    pulse(E_BOR);
    pc_is(13'h0000);
    rck(8'h03, 8'h15);
    rck(8'h8e, 8'h00);
    rck(8'h9f, 8'h00);
    wr(8'h01, 8'h77);
    pulse(E_ON | E_EXT);
    rck(8'h03, 8'h18);
    rck(8'h01, 8'h00);
    // Comparator set and software clear in one cycle: the set wins
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= 8'h0c;
    reg_wdata <= 8'h00;
    ev <= E_CMP;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    ev <= '0;
    rck(8'h0c, 8'h40);
    $display("test brown-out and power-on done");
    // Quarter clock: two transitions every four cycles
    @(posedge sys_clk);
    rc_mode <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    for (int pass = 0; pass < 2; pass++) begin
      edges = 0;
      q = quarter_osc_output;
      repeat (16) begin
        @(posedge sys_clk);
        #1;
        if (quarter_osc_output !== q) edges++;
        q = quarter_osc_output;
      end
      chk("quarter clock edges", 16'(edges), pass == 0 ? 16'd8 : 16'd0);
      @(posedge sys_clk);
      rc_mode <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
    end
    chk("quarter clock idle", 16'(quarter_osc_output), 16'h0);
    $display("test quarter clock done");
    finish_test();
  end
endmodule
